// File: core/cfe_pkg.sv
// Shared constants and types for the CAN receive filter and error status block.
package cfe_pkg;

   // Register bus widths.
   localparam int unsigned CFE_AW = 8;
   localparam int unsigned CFE_DW = 8;

   // Register offsets on the plain register port.
   localparam logic [7:0] CFE_OFS_MISC = 8'h00;
   localparam logic [7:0] CFE_OFS_RXERR = 8'h01;
   localparam logic [7:0] CFE_OFS_TXERR = 8'h02;
   localparam logic [7:0] CFE_OFS_FCTL = 8'h03;
   localparam logic [7:0] CFE_OFS_MODE = 8'h04;
   localparam logic [7:0] CFE_OFS_CODE_BASE = 8'h10;
   localparam logic [7:0] CFE_OFS_MASK_BASE = 8'h18;

   // Field positions.
   localparam int unsigned CFE_BOH_BIT = 0;
   localparam int unsigned CFE_ORG_LSB = 4;
   localparam int unsigned CFE_HIT_LSB = 0;
   localparam int unsigned CFE_MODE_INIT_BIT = 0;
   localparam int unsigned CFE_MODE_SLEEP_BIT = 1;
   localparam int unsigned CFE_MODE_HOLD_BIT = 2;

   // Count of acceptance code and mask registers.
   localparam int unsigned CFE_NUM_ACC = 8;

   // Filter organisation encoding.
   typedef enum logic [1:0] {
      CFE_ORG_32 = 2'b00,
      CFE_ORG_16 = 2'b01,
      CFE_ORG_8 = 2'b10,
      CFE_ORG_CLOSED = 2'b11
   } cfe_org_type;

   // Values after reset.
   localparam logic [7:0] CFE_CODE_RST = 8'h00;
   localparam logic [7:0] CFE_MASK_RST = 8'h00;
   localparam cfe_org_type CFE_ORG_RST = CFE_ORG_32;
   localparam logic [2:0] CFE_HIT_RST = 3'h0;
   localparam logic [7:0] CFE_RDATA_RST = 8'h00;

endpackage : cfe_pkg

// File: core/cfe_filt_if.sv
// Interface between register file, receive stage and identifier matcher.
`timescale 1ns/1ps
interface cfe_filt_if;
   import cfe_pkg::*;
   logic [7:0][7:0] code;
   logic [7:0][7:0] mask;
   cfe_org_type org;
   logic [3:0][7:0] idr;
   logic ide;
   logic hit;
   logic [2:0] hit_idx;
   logic [2:0] fg_hit;

   modport regs (output code, output mask, output org, input fg_hit);
   modport match (input code, input mask, input org, input idr, input ide,
      output hit, output hit_idx);
   modport stage (output idr, output ide, input hit, input hit_idx, output fg_hit);
endinterface : cfe_filt_if

// File: core/cfe_id_match.sv
// Identifier acceptance matcher: compares the background identifier with all filters.
`timescale 1ns/1ps
module cfe_id_match
   import cfe_pkg::*;
(
   cfe_filt_if.match fi
);

   // A byte matches when every bit left unmasked equals the code bit.
   function automatic logic byte_ok(input logic [7:0] c, input logic [7:0] m,
      input logic [7:0] id);
      byte_ok = &((~(c ^ id)) | m);
   endfunction : byte_ok

   logic [7:0] f_ok;

   // Each filter checks the bytes that its organisation assigns to it.
   always_comb begin
      f_ok = 8'h00;
      unique case (fi.org)
         CFE_ORG_32: begin
            for (int b = 0; b < 2; b++) begin
               f_ok[b] = byte_ok(fi.code[4*b], fi.mask[4*b], fi.idr[0])
                  & byte_ok(fi.code[4*b+1], fi.mask[4*b+1], fi.idr[1])
                  & (!fi.ide | (byte_ok(fi.code[4*b+2], fi.mask[4*b+2], fi.idr[2])
                  & byte_ok(fi.code[4*b+3], fi.mask[4*b+3], fi.idr[3])));
            end
         end
         CFE_ORG_16: begin
            for (int k = 0; k < 4; k++) begin
               f_ok[k] = byte_ok(fi.code[2*k], fi.mask[2*k], fi.idr[0])
                  & byte_ok(fi.code[2*k+1], fi.mask[2*k+1], fi.idr[1]);
            end
         end
         CFE_ORG_8: begin
            for (int k = 0; k < 8; k++) begin
               f_ok[k] = byte_ok(fi.code[k], fi.mask[k], fi.idr[0]);
            end
         end
         CFE_ORG_CLOSED: f_ok = 8'h00;
      endcase
   end

   // The lowest numbered filter that hits is reported.
   always_comb begin
      fi.hit = |f_ok;
      fi.hit_idx = 3'h0;
      for (int k = 7; k >= 0; k--) begin
         if (f_ok[k]) begin
            fi.hit_idx = 3'(k);
         end
      end
   end

endmodule : cfe_id_match

// File: core/cfe_rx_stage.sv
// Receive stage: background identifier buffer and foreground shift on acceptance.
`timescale 1ns/1ps
module cfe_rx_stage
   import cfe_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic rx_valid,
   input wire logic [31:0] rx_id,
   input wire logic rx_ide,
   output logic [31:0] fg_id,
   output logic fg_ide,
   output logic msg_ready,
   cfe_filt_if.stage fi
);

   typedef struct packed {
      logic [31:0] bg_id;
      logic bg_ide;
      logic pend;
      logic [31:0] fg_id;
      logic fg_ide;
      logic [2:0] hit;
      logic ready;
   } cfe_stage_type;

   cfe_stage_type st_q;
   cfe_stage_type st_d;

   // Every message lands in the background buffer; a rejected one is simply overwritten.
   always_comb begin
      st_d = st_q;
      st_d.ready = 1'b0;
      if (st_q.pend && fi.hit) begin
         st_d.fg_id = st_q.bg_id;
         st_d.fg_ide = st_q.bg_ide;
         st_d.hit = fi.hit_idx;
         st_d.ready = 1'b1;
      end
      st_d.pend = 1'b0;
      if (rx_valid) begin
         st_d.bg_id = rx_id;
         st_d.bg_ide = rx_ide;
         st_d.pend = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign fi.idr = {st_q.bg_id[7:0], st_q.bg_id[15:8], st_q.bg_id[23:16], st_q.bg_id[31:24]};
   assign fi.ide = st_q.bg_ide;
   assign fi.fg_hit = st_q.hit;
   assign fg_id = st_q.fg_id;
   assign fg_ide = st_q.fg_ide;
   assign msg_ready = st_q.ready;

endmodule : cfe_rx_stage

// File: core/cfe_top.sv
// Register file, bus-off hold flag and receive identifier filtering of the CAN unit.
`timescale 1ns/1ps

module cfe_top
   import cfe_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [CFE_AW-1:0] reg_addr,
   input wire logic [CFE_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [CFE_DW-1:0] reg_rdata,
   input wire logic init_request,
   input wire logic init_acknowledge,
   input wire logic sleep_request,
   input wire logic sleep_acknowledge,
   input wire logic bus_off_recovery_select,
   input wire logic bus_off_entry,
   input wire logic [7:0] rx_err_count,
   input wire logic [7:0] tx_err_count,
   input wire logic rx_valid,
   input wire logic [31:0] rx_id,
   input wire logic rx_ide,
   output logic bus_off_hold_flag,
   output logic recovery_request,
   output logic rx_msg_ready,
   output logic [31:0] fg_id,
   output logic fg_ide,
   output cfe_org_type filter_organisation
);

   // Register file state; all of it sits in one packed record.
   typedef struct packed {
      logic [7:0][7:0] code;
      logic [7:0][7:0] mask;
      cfe_org_type org;
      logic hold;
      logic recov;
      logic [CFE_DW-1:0] rdata;
   } cfe_regs_type;

   cfe_regs_type r_q;
   cfe_regs_type r_d;

   cfe_filt_if fi ();

   logic init_mode;
   logic sleep_mode;
   logic hold_set;
   logic hold_clr;

   // Selects whether an address falls in the code bank, the mask bank, or neither.
   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      in_bank = (a[7:3] == base[7:3]);
   endfunction : in_bank

   // Both halves of the handshake must agree before a mode counts as entered.
   assign init_mode = init_request & init_acknowledge;
   assign sleep_mode = sleep_request & sleep_acknowledge;

   // Bus-off entry and software clear of the hold flag.
   assign hold_set = bus_off_entry & bus_off_recovery_select;
   assign hold_clr = reg_wr & (reg_addr == CFE_OFS_MISC) & reg_wdata[CFE_BOH_BIT];

   // Next state of the register file.
   always_comb begin
      r_d = r_q;
      r_d.recov = 1'b0;
      r_d.rdata = CFE_RDATA_RST;

      // A new bus-off entry wins over a clear arriving in the same cycle.
      if (hold_set) begin
         r_d.hold = 1'b1;
      end else if (hold_clr) begin
         r_d.hold = 1'b0;
         r_d.recov = r_q.hold;
      end

      // Filter setup may only change while the controller is held in init mode,
      // so the matcher never sees a half-written filter on live traffic.
      if (reg_wr && init_mode) begin
         if (in_bank(reg_addr, CFE_OFS_CODE_BASE)) begin
            r_d.code[reg_addr[2:0]] = reg_wdata;
         end
         if (in_bank(reg_addr, CFE_OFS_MASK_BASE)) begin
            r_d.mask[reg_addr[2:0]] = reg_wdata;
         end
         if (reg_addr == CFE_OFS_FCTL) begin
            r_d.org = cfe_org_type'(reg_wdata[CFE_ORG_LSB +: 2]);
         end
      end

      // Read path; data stand in the cycle after the strobe only.
      if (reg_rd) begin
         if (in_bank(reg_addr, CFE_OFS_CODE_BASE)) begin
            r_d.rdata = r_q.code[reg_addr[2:0]];
         end else if (in_bank(reg_addr, CFE_OFS_MASK_BASE)) begin
            r_d.rdata = r_q.mask[reg_addr[2:0]];
         end else begin
            unique case (reg_addr)
               CFE_OFS_MISC: begin
                  r_d.rdata[CFE_BOH_BIT] = r_q.hold;
               end
               // The counts are only coherent in sleep or init mode; elsewhere the
               // live value is returned and may be in the middle of an update.
               CFE_OFS_RXERR: r_d.rdata = rx_err_count;
               CFE_OFS_TXERR: r_d.rdata = tx_err_count;
               CFE_OFS_FCTL: begin
                  r_d.rdata[CFE_ORG_LSB +: 2] = r_q.org;
                  r_d.rdata[CFE_HIT_LSB +: 3] = fi.fg_hit;
               end
               CFE_OFS_MODE: begin
                  r_d.rdata[CFE_MODE_INIT_BIT] = init_mode;
                  r_d.rdata[CFE_MODE_SLEEP_BIT] = sleep_mode;
                  r_d.rdata[CFE_MODE_HOLD_BIT] = r_q.hold;
               end
               default: r_d.rdata = CFE_RDATA_RST;
            endcase
         end
      end
   end

   // Register file flip-flops.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q.code <= {CFE_NUM_ACC{CFE_CODE_RST}};
         r_q.mask <= {CFE_NUM_ACC{CFE_MASK_RST}};
         r_q.org <= CFE_ORG_RST;
         r_q.hold <= 1'b0;
         r_q.recov <= 1'b0;
         r_q.rdata <= CFE_RDATA_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // Filter configuration goes to the matcher.
   assign fi.code = r_q.code;
   assign fi.mask = r_q.mask;
   assign fi.org = r_q.org;

   // Matcher works on the background buffer held in the receive stage.
   cfe_id_match u_match (
      .fi(fi.match)
   );

   cfe_rx_stage u_stage (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .rx_valid(rx_valid),
      .rx_id(rx_id),
      .rx_ide(rx_ide),
      .fg_id(fg_id),
      .fg_ide(fg_ide),
      .msg_ready(rx_msg_ready),
      .fi(fi.stage)
   );

   // Top outputs straight from flip-flops.
   assign reg_rdata = r_q.rdata;
   assign bus_off_hold_flag = r_q.hold;
   assign recovery_request = r_q.recov;
   assign filter_organisation = r_q.org;

endmodule : cfe_top

// File: verif/cfe_assertions.sv
// Port-level checks for the CAN filter and error status block.
`timescale 1ns/1ps
module cfe_checker
   import cfe_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [CFE_AW-1:0] reg_addr,
   input wire logic [CFE_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [CFE_DW-1:0] reg_rdata,
   input wire logic init_request,
   input wire logic init_acknowledge,
   input wire logic bus_off_recovery_select,
   input wire logic bus_off_entry,
   input wire logic [7:0] rx_err_count,
   input wire logic [7:0] tx_err_count,
   input wire logic rx_valid,
   input wire logic bus_off_hold_flag,
   input wire logic recovery_request,
   input wire logic rx_msg_ready,
   input wire logic [31:0] fg_id,
   input wire cfe_org_type filter_organisation
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Software writes a one to the hold bit.
   sequence s_clr_wr;
      reg_wr && reg_addr == CFE_OFS_MISC && reg_wdata[CFE_BOH_BIT];
   endsequence
   // The engine reports bus-off with user recovery selected.
   sequence s_boff;
      bus_off_entry && bus_off_recovery_select;
   endsequence
   a_hold_set: assert property (s_boff |=> bus_off_hold_flag)
      else $error("hold flag not set");
   a_hold_keep: assert property (bus_off_hold_flag
      && !(reg_wr && reg_addr == CFE_OFS_MISC && reg_wdata[CFE_BOH_BIT])
      |=> bus_off_hold_flag) else $error("hold flag dropped");
   a_clr_req: assert property (s_clr_wr ##0 (bus_off_hold_flag && !bus_off_entry)
      |=> !bus_off_hold_flag && recovery_request) else $error("clear failed");
   a_req_cause: assert property (recovery_request
      |-> $past(bus_off_hold_flag) && $past(reg_wr)) else $error("stray recovery");
   a_rx_count: assert property (reg_rd && reg_addr == CFE_OFS_RXERR
      |=> reg_rdata == $past(rx_err_count)) else $error("rx count wrong");
   a_tx_count: assert property (reg_rd && reg_addr == CFE_OFS_TXERR
      |=> reg_rdata == $past(tx_err_count)) else $error("tx count wrong");
   a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside slot");
   a_org_lock: assert property (!(init_request && init_acknowledge)
      |=> $stable(filter_organisation)) else $error("org changed");
   a_rdy_cause: assert property (rx_msg_ready |-> $past(rx_valid, 2))
      else $error("ready without message");
   a_fg_hold: assert property (!rx_msg_ready |-> $stable(fg_id))
      else $error("foreground changed");
   a_closed_reject: assert property (filter_organisation == CFE_ORG_CLOSED && rx_valid
      ##1 filter_organisation == CFE_ORG_CLOSED |=> !rx_msg_ready) else $error("closed hit");
endmodule : cfe_checker
bind cfe_top cfe_checker i_chk (
   .core_clk(core_clk),
   .arst_n(arst_n),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .init_request(init_request),
   .init_acknowledge(init_acknowledge),
   .bus_off_recovery_select(bus_off_recovery_select),
   .bus_off_entry(bus_off_entry),
   .rx_err_count(rx_err_count),
   .tx_err_count(tx_err_count),
   .rx_valid(rx_valid),
   .bus_off_hold_flag(bus_off_hold_flag),
   .recovery_request(recovery_request),
   .rx_msg_ready(rx_msg_ready),
   .fg_id(fg_id),
   .filter_organisation(filter_organisation)
);

// File: verif/cfe_node_model.sv
// Remote CAN nodes: offer received identifiers to the receive stage.
`timescale 1ns/1ps
module cfe_node_model
(
   input wire logic core_clk,
   output logic rx_valid,
   output logic [31:0] rx_id,
   output logic rx_ide
);
   initial begin
      rx_valid = 1'h0;
      rx_id = 32'h0;
      rx_ide = 1'h0;
   end
   // One frame for one cycle; afterwards the stale value is inverted so nothing leans on it.
   task automatic send(input logic [31:0] id, input logic ide);
      @(posedge core_clk);
      rx_valid <= 1'h1;
      rx_id <= id;
      rx_ide <= ide;
      @(posedge core_clk);
      rx_valid <= 1'h0;
      rx_id <= ~id;
      rx_ide <= ~ide;
   endtask : send
endmodule : cfe_node_model

// File: verif/test_can_rx_filter_and_error_status.sv
// Self-checking bench for the CAN receive filter and error status block.
`timescale 1ns/1ps
module test_can_rx_filter_and_error_status
   import cfe_pkg::*;
;
   typedef struct packed {logic [1:0] org; logic [31:0] id; logic ide; logic acc;
      logic [2:0] hit;} cfe_case_type;
   logic core_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic init_request = 1'h0, init_acknowledge = 1'h0, bus_off_entry = 1'h0;
   logic sleep_request = 1'h0, sleep_acknowledge = 1'h0, bus_off_recovery_select = 1'h0;
   logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, rx_err_count = 8'h0, tx_err_count = 8'h0;
   logic rx_valid, rx_ide, bus_off_hold_flag, recovery_request, rx_msg_ready, fg_ide;
   logic [7:0] reg_rdata;
   logic [31:0] rx_id, fg_id;
   cfe_org_type filter_organisation;
   int n_errors = 0, samples_checked = 0;
   always #5 core_clk = ~core_clk;
   cfe_node_model i_node (.core_clk(core_clk), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(rx_ide));
   cfe_top i_dut (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .init_request(init_request),
      .init_acknowledge(init_acknowledge),
      .sleep_request(sleep_request),
      .sleep_acknowledge(sleep_acknowledge),
      .bus_off_recovery_select(bus_off_recovery_select),
      .bus_off_entry(bus_off_entry),
      .rx_err_count(rx_err_count),
      .tx_err_count(tx_err_count),
      .rx_valid(rx_valid),
      .rx_id(rx_id),
      .rx_ide(rx_ide),
      .bus_off_hold_flag(bus_off_hold_flag),
      .recovery_request(recovery_request),
      .rx_msg_ready(rx_msg_ready),
      .fg_id(fg_id),
      .fg_ide(fg_ide),
      .filter_organisation(filter_organisation)
   );
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Register bus cycles: strobes change right after an edge and last one cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      chk(what, exp, reg_rdata);
   endtask : rd
   task automatic mode(input logic on);
      @(posedge core_clk);
      init_request <= on;
      init_acknowledge <= on;
   endtask : mode
   task automatic boff(input logic sel);
      @(posedge core_clk);
      bus_off_recovery_select <= sel;
      bus_off_entry <= 1'h1;
      @(posedge core_clk);
      bus_off_entry <= 1'h0;
      #1;
   endtask : boff
   task automatic t_regs();
      rd(CFE_OFS_MASK_BASE + 8'h07, CFE_MASK_RST, "mask7 reset");
      rd(8'h40, 8'h00, "unmapped");
      wr(CFE_OFS_CODE_BASE, 8'h5a);
      rd(CFE_OFS_CODE_BASE, CFE_CODE_RST, "code0 locked");
      wr(CFE_OFS_FCTL, 8'h30);
      rd(CFE_OFS_FCTL, 8'h00, "org locked");
      $display("t_regs done");
   endtask : t_regs
   task automatic t_hold();
      boff(1'h0);
      chk("hold unselected", 1'h0, bus_off_hold_flag);
      boff(1'h1);
      chk("hold set", 1'h1, bus_off_hold_flag);
      wr(CFE_OFS_MISC, 8'hfe);
      rd(CFE_OFS_MISC, 8'h01, "zero write");
      wr(CFE_OFS_MISC, 8'h01);
      chk("recovery", 1'h1, recovery_request);
      rd(CFE_OFS_MISC, 8'h00, "hold cleared");
      $display("t_hold done");
   endtask : t_hold
   // Counters are read in sleep, then in init mode, after a write that must not stick.
   task automatic t_err();
      @(posedge core_clk);
      rx_err_count <= 8'h5a;
      tx_err_count <= 8'ha5;
      sleep_request <= 1'h1;
      sleep_acknowledge <= 1'h1;
      wr(CFE_OFS_RXERR, 8'h00);
      rd(CFE_OFS_RXERR, 8'h5a, "rx count");
      rd(CFE_OFS_MODE, 8'h02, "sleep mode");
      @(posedge core_clk);
      sleep_request <= 1'h0;
      sleep_acknowledge <= 1'h0;
      mode(1'h1);
      wr(CFE_OFS_TXERR, 8'h00);
      rd(CFE_OFS_TXERR, 8'ha5, "tx count");
      rd(CFE_OFS_MODE, 8'h01, "init mode");
      mode(1'h0);
      $display("t_err done");
   endtask : t_err
   // Codes are 11h..88h; odd masks leave the three low bits open in standard and extended frames alike.
   task automatic t_filter();
      cfe_case_type tab [11] = '{'{2'h0, 32'h11223344, 1'h1, 1'h1, 3'h0},
         '{2'h0, 32'h1122334c, 1'h1, 1'h0, 3'h0}, '{2'h0, 32'h11223347, 1'h1, 1'h1, 3'h0},
         '{2'h0, 32'h55667788, 1'h1, 1'h1, 3'h1}, '{2'h0, 32'h1125ffff, 1'h0, 1'h1, 3'h0},
         '{2'h1, 32'h33440000, 1'h1, 1'h1, 3'h1}, '{2'h1, 32'h77890000, 1'h0, 1'h1, 3'h3},
         '{2'h1, 32'h99000000, 1'h1, 1'h0, 3'h0}, '{2'h2, 32'h66000000, 1'h1, 1'h1, 3'h5},
         '{2'h2, 32'h6e000000, 1'h1, 1'h0, 3'h0}, '{2'h3, 32'h11223344, 1'h1, 1'h0, 3'h0}};
      logic [31:0] last = 32'h0;
      logic last_ide = 1'h0;
      mode(1'h1);
      for (int n = 0; n < 8; n++) begin
         wr(CFE_OFS_CODE_BASE + 8'(n), 8'(8'h11 * (n + 1)));
         wr(CFE_OFS_MASK_BASE + 8'(n), n[0] ? 8'h07 : 8'h00);
      end
      foreach (tab[i]) begin
         mode(1'h1);
         wr(CFE_OFS_FCTL, {2'h0, tab[i].org, 4'h0});
         chk("org", tab[i].org, filter_organisation);
         mode(1'h0);
         i_node.send(tab[i].id, tab[i].ide);
         @(posedge core_clk);
         #1;
         chk("ready", tab[i].acc, rx_msg_ready);
         if (tab[i].acc) begin
            last = tab[i].id;
            last_ide = tab[i].ide;
         end
         chk("fg id", last, fg_id);
         chk("fg ide", last_ide, fg_ide);
         if (tab[i].acc) rd(CFE_OFS_FCTL, {2'h0, tab[i].org, 1'h0, tab[i].hit}, "hit");
      end
      $display("t_filter done");
   endtask : t_filter
   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (12) @(posedge core_clk);
      arst_n <= 1'h1;
      t_regs();
      t_hold();
      t_err();
      t_filter();
      complete_run();
   end
   // The tests need under two hundred cycles; the limit of 5000 cycles means a hang.
   initial begin
      #50us;
      n_errors++;
      complete_run();
   end
endmodule : test_can_rx_filter_and_error_status
